// >>> core/lcr_ctrl.sv
// led channel control registers with i2c slave and 32 kHz execution engines
// Notes on behaviour
// R1: bit 7 selects logarithmic duty shaping
// R2: setting master enable launches start-up
// R3: enable pin low clears master enable
// R4: hold code stops channel after current instruction
// R5: host touches counter only while holding
// R6: step executes, increments, returns to hold
// R7: run executes continuously from counter
// R8: once executes without increment, returns hold
// R9: execution fields synchronised to 32 kHz
// R10: host spaces enable writes over 488 us
// R11: function code 00 disables channel
// R12: load function resets channel counter
// R13: program function runs stored program
// R14: direct function drives duty from registers
// R15: function fields synchronised to 32 kHz
// R16: host spaces function writes over 153 us
// R17: drive level register resets to AF
// R18: duty register writes act immediately
// R19: execution advances only in program function
`include "lcr_regs.svh"
module lcr_ctrl
  import lcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A  // arbitrary bus address
) (
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_32k_i,
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  input  wire logic             en_pin_i,
  output logic                  log_shape_o,
  output logic                  chip_en_o,
  output logic                  startup_o,
  output logic [7:0]            red_drive_o,
  output logic [2:0][7:0]       duty_o,
  output logic [2:0]            instr_o,
  output logic [2:0][3:0]       pc_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] shape(input logic [7:0] d, input logic lg);
    logic [15:0] sq;
    sq = 16'(d) * 16'(d);
    return lg ? sq[15:8] : d;
  endfunction : shape
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]  scl_sy_r, sda_sy_r, en_sy_r;
  logic        scl_s_r, sda_s_r, en_s_r, scl_d_r, sda_d_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {scl_sy_r, sda_sy_r, scl_s_r, sda_s_r, scl_d_r, sda_d_r} <= 10'h3FF;
      {en_sy_r, en_s_r} <= 4'h0;
    end else begin
      scl_sy_r <= {scl_sy_r[1:0], scl_i};
      sda_sy_r <= {sda_sy_r[1:0], sda_i};
      en_sy_r  <= {en_sy_r[1:0], en_pin_i};
      if (scl_sy_r[1] == scl_sy_r[2]) scl_s_r <= scl_sy_r[2];
      if (sda_sy_r[1] == sda_sy_r[2]) sda_s_r <= sda_sy_r[2];
      if (en_sy_r[1] == en_sy_r[2]) en_s_r <= en_sy_r[2];
      scl_d_r  <= scl_s_r;
      sda_d_r  <= sda_s_r;
    end
  end
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign i2c_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign i2c_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  // ----------------------------------------------------------------
  // i2c slave
  // ----------------------------------------------------------------
  lcr_i2c_type st_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r, tx_r, ptr_r, rd_data;
  logic        oe_r, wr_en_r;
  lcr_wr_type  wr_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= IS_IDLE;
      {cnt_r, sh_r, tx_r, ptr_r, oe_r, wr_en_r, wr_r} <= 46'h0;
    end else begin
      wr_en_r <= 1'b0;
      if (i2c_start) begin
        st_r  <= IS_DEV;
        cnt_r <= 4'h0;
        oe_r  <= 1'b0;
      end else if (i2c_stop) begin
        st_r <= IS_IDLE;
        oe_r <= 1'b0;
      end else if (st_r != IS_IDLE && scl_rise) begin
        if (cnt_r < 4'h8) begin
          sh_r  <= {sh_r[6:0], sda_s_r};
          cnt_r <= cnt_r + 4'h1;
        end else begin
          cnt_r <= 4'h9;
          if (st_r == IS_RDAT && sda_s_r) st_r <= IS_IDLE;
        end
      end else if (st_r != IS_IDLE && scl_fall) begin
        if (cnt_r == 4'h8) begin
          unique case (st_r)
            IS_DEV: begin
              if (sh_r[7:1] == DEV_ADDR) begin
                oe_r <= 1'b1;
                st_r <= sh_r[0] ? IS_RDAT : IS_REG;
              end else begin
                st_r <= IS_IDLE;
              end
            end
            IS_REG: begin
              ptr_r <= sh_r;
              oe_r  <= 1'b1;
              st_r  <= IS_WDAT;
            end
            IS_WDAT: begin
              wr_en_r <= 1'b1;
              wr_r    <= '{addr: ptr_r, data: sh_r};
              ptr_r   <= ptr_r + 8'h01;
              oe_r    <= 1'b1;
            end
            IS_RDAT, IS_IDLE: oe_r <= 1'b0;
          endcase
        end else if (cnt_r == 4'h9) begin
          cnt_r <= 4'h0;
          oe_r  <= 1'b0;
          if (st_r == IS_RDAT) begin
            tx_r  <= rd_data;
            ptr_r <= ptr_r + 8'h01;
            oe_r  <= ~rd_data[7];
          end
        end else if (st_r == IS_RDAT && cnt_r != 4'h0) begin
          oe_r <= ~tx_r[3'(4'h7 - cnt_r)];
        end
      end
    end
  end
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_r;
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0]      ctrl_r, func_r, drv_r;
  logic [2:0][7:0] pwm_r;
  logic [2:0]      done_edge;
  logic [1:0]      tog_r;
  logic [5:0]      xexec_r, xfunc_r;
  logic            ctrl_wr, func_wr;
  assign ctrl_wr = wr_en_r && wr_r.addr == `LCR_OFS_CTRL;
  assign func_wr = wr_en_r && wr_r.addr == `LCR_OFS_FUNC;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= `LCR_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= wr_r.data;
      end else begin
        for (int c = 0; c < 3; c++) begin
          if (done_edge[c]) ctrl_r[2*c +: 2] <= EX_HOLD;  // [R6] [R8]
        end
      end
      if (!en_s_r) ctrl_r[`LCR_CHIP_BIT] <= 1'b0;  // [R3]
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      func_r <= `LCR_FUNC_RST;
      drv_r  <= `LCR_DRV_RST;  // [R17]
      pwm_r  <= {3{`LCR_DUTY_RST}};
    end else if (wr_en_r) begin
      unique case (wr_r.addr)
        `LCR_OFS_FUNC:  func_r <= {2'h0, wr_r.data[5:0]};
        `LCR_OFS_RDUTY: pwm_r[`LCR_RED] <= wr_r.data;
        `LCR_OFS_GDUTY: pwm_r[`LCR_GREEN] <= wr_r.data;
        `LCR_OFS_BDUTY: pwm_r[`LCR_BLUE] <= wr_r.data;
        `LCR_OFS_RDRV:  drv_r <= wr_r.data;
        default:        drv_r <= drv_r;
      endcase
    end
  end
  always_comb begin
    unique case (ptr_r)
      `LCR_OFS_CTRL:  rd_data = ctrl_r;
      `LCR_OFS_FUNC:  rd_data = func_r;
      `LCR_OFS_RDUTY: rd_data = pwm_r[`LCR_RED];
      `LCR_OFS_GDUTY: rd_data = pwm_r[`LCR_GREEN];
      `LCR_OFS_BDUTY: rd_data = pwm_r[`LCR_BLUE];
      `LCR_OFS_RDRV:  rd_data = drv_r;
      default:        rd_data = 8'h00;
    endcase
  end
  // shadow words held stable for the slow side
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {xexec_r, xfunc_r, tog_r} <= 14'h0;
    end else begin
      if (ctrl_wr) begin
        xexec_r  <= wr_r.data[5:0];
        tog_r[0] <= ~tog_r[0];  // [R9]
      end
      if (func_wr) begin
        xfunc_r  <= wr_r.data[5:0];
        tog_r[1] <= ~tog_r[1];  // [R15]
      end
    end
  end
  logic [2:0][7:0] duty_r;
  logic            start_r, chip_d_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {duty_r, start_r, chip_d_r} <= 26'h0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        duty_r[c] <= (func_r[2*c +: 2] == FN_DIRECT) ?  // [R14] [R18] [R11]
                     shape(pwm_r[c], ctrl_r[`LCR_LOG_BIT]) : 8'h00;  // [R1]
      end
      chip_d_r <= ctrl_r[`LCR_CHIP_BIT];
      start_r  <= ctrl_r[`LCR_CHIP_BIT] & ~chip_d_r;  // [R2]
    end
  end
  assign duty_o      = duty_r;
  assign log_shape_o = ctrl_r[`LCR_LOG_BIT];
  assign chip_en_o   = chip_d_r;
  assign startup_o   = start_r;
  assign red_drive_o = drv_r;
  // ----------------------------------------------------------------
  // clock crossings and slow side reset release
  // ----------------------------------------------------------------
  logic [2:0]      dn_tog_r;
  logic [2:0][2:0] dn_sy_r;
  logic [2:0]      dn_s_r, dn_d_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {dn_sy_r, dn_s_r, dn_d_r} <= 15'h0;
    end else begin
      for (int c = 0; c < 3; c++) begin
        dn_sy_r[c] <= {dn_sy_r[c][1:0], dn_tog_r[c]};
        if (dn_sy_r[c][1] == dn_sy_r[c][2]) dn_s_r[c] <= dn_sy_r[c][2];
      end
      dn_d_r <= dn_s_r;
    end
  end
  assign done_edge = dn_s_r ^ dn_d_r;
  logic [1:0]      rst32_r;
  logic [1:0][2:0] cf_sy_r;
  logic [1:0]      cf_s_r, cf_d_r, cap;
  always_ff @(posedge clk_32k_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {rst32_r, cf_sy_r, cf_s_r, cf_d_r} <= 12'h000;
    end else begin
      rst32_r <= {rst32_r[0], 1'b1};
      for (int k = 0; k < 2; k++) begin
        cf_sy_r[k] <= {cf_sy_r[k][1:0], tog_r[k]};
        if (cf_sy_r[k][1] == cf_sy_r[k][2]) cf_s_r[k] <= cf_sy_r[k][2];
      end
      cf_d_r <= cf_s_r;
    end
  end
  assign cap = cf_s_r ^ cf_d_r;
  // ----------------------------------------------------------------
  // 32 kHz domain: execution engines
  // ----------------------------------------------------------------
  lcr_exec_type [2:0] lexec_r;
  lcr_func_type [2:0] lfunc_r;
  logic [2:0][3:0]    pc_r;
  logic [2:0]         instr_r;
  always_ff @(posedge clk_32k_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lexec_r  <= {3{EX_HOLD}};
      lfunc_r  <= {3{FN_OFF}};
      {pc_r, instr_r, dn_tog_r} <= 18'h0;
    end else if (rst32_r[1]) begin
      for (int c = 0; c < 3; c++) begin
        instr_r[c] <= 1'b0;
        if (cap[0]) begin
          lexec_r[c] <= lcr_exec_type'(xexec_r[2*c +: 2]);  // [R9]
        end else if (lfunc_r[c] == FN_PROG) begin  // [R13] [R19]
          unique case (lexec_r[c])
            EX_HOLD: instr_r[c] <= 1'b0;  // [R4] [R5]
            EX_STEP: begin
              instr_r[c]  <= 1'b1;
              pc_r[c]     <= pc_r[c] + 4'h1;  // [R6]
              lexec_r[c]  <= EX_HOLD;
              dn_tog_r[c] <= ~dn_tog_r[c];
            end
            EX_RUN: begin
              instr_r[c] <= 1'b1;
              pc_r[c]    <= pc_r[c] + 4'h1;  // [R7]
            end
            EX_ONCE: begin
              instr_r[c]  <= 1'b1;  // [R8]
              lexec_r[c]  <= EX_HOLD;
              dn_tog_r[c] <= ~dn_tog_r[c];
            end
          endcase
        end
        if (cap[1]) begin
          lfunc_r[c] <= lcr_func_type'(xfunc_r[2*c +: 2]);  // [R15]
          if (xfunc_r[2*c +: 2] == FN_LOAD) pc_r[c] <= 4'h0;  // [R12]
        end
      end
    end
  end
  assign pc_o    = pc_r;
  assign instr_o = instr_r;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int R = `LCR_RED;
  log_duty_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R1]
    func_r[5:4] == FN_DIRECT && ctrl_r[7] |=> duty_o[R] == shape($past(pwm_r[R]), 1'b1))
    else $error("log duty wrong");
  lin_duty_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R14]
    func_r[5:4] == FN_DIRECT && !ctrl_r[7] |=> duty_o[R] == $past(pwm_r[R]))
    else $error("direct duty wrong");
  duty_now_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R18]
    wr_en_r && wr_r.addr == `LCR_OFS_RDUTY && func_r[5:4] == FN_DIRECT && !ctrl_r[7]
    |-> ##2 duty_o[R] == $past(wr_r.data, 2))
    else $error("duty write late");
  off_duty_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R11]
    func_r[5:4] == FN_OFF |=> duty_o[R] == 8'h00)
    else $error("disabled channel lit");
  startup_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R2]
    $rose(chip_en_o) |-> startup_o)
    else $error("no start pulse");
  en_force_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R3]
    !en_s_r |=> !ctrl_r[`LCR_CHIP_BIT] ##1 !chip_en_o)
    else $error("enable not cleared");
  hold_back_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)  // [R6]
    done_edge[R] && !ctrl_wr |=> ctrl_r[5:4] == EX_HOLD)
    else $error("field not returned to hold");
  hold_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R4]
    lexec_r[R] == EX_HOLD && !cap[1] |=> $stable(pc_r[R]) && !instr_r[R])
    else $error("hold advanced");
  step_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R6]
    lfunc_r[R] == FN_PROG && lexec_r[R] == EX_STEP && cap == 2'h0
    |=> pc_r[R] == $past(pc_r[R]) + 4'h1 && lexec_r[R] == EX_HOLD && instr_r[R])
    else $error("step wrong");
  once_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R8]
    lfunc_r[R] == FN_PROG && lexec_r[R] == EX_ONCE && cap == 2'h0
    |=> $stable(pc_r[R]) && lexec_r[R] == EX_HOLD && instr_r[R])
    else $error("once wrong");
  run_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R7]
    (lfunc_r[R] == FN_PROG && lexec_r[R] == EX_RUN && cap == 2'h0) [*2]
    |=> pc_r[R] == $past(pc_r[R], 2) + 4'h2)
    else $error("run not continuous");
  load_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R12]
    cap[1] && xfunc_r[5:4] == FN_LOAD |=> pc_r[R] == 4'h0)
    else $error("load kept counter");
  idle_pc_a: assert property (@(posedge clk_32k_i) disable iff (!rst32_r[1])  // [R19]
    lfunc_r[R] != FN_PROG && !cap[1] |=> $stable(pc_r[R]) && !instr_r[R])
    else $error("idle channel ran");
  step_c: cover property (@(posedge clk_32k_i) disable iff (!rst32_r[1])
    lexec_r[R] == EX_STEP ##1 instr_r[R]);
  direct_c: cover property (@(posedge mclk_i) disable iff (!resetn_i)
    func_r[5:4] == FN_DIRECT ##1 duty_o[R] != 8'h00);
  start_c: cover property (@(posedge mclk_i) disable iff (!resetn_i) startup_o);
endmodule : lcr_ctrl

// >>> inc/lcr_regs.svh
// register offsets, reset values, field positions and timing figures
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH
// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define LCR_OFS_CTRL      8'h00
`define LCR_OFS_FUNC      8'h01
`define LCR_OFS_RDUTY     8'h02
`define LCR_OFS_GDUTY     8'h03
`define LCR_OFS_BDUTY     8'h04
`define LCR_OFS_RDRV      8'h05
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define LCR_CTRL_RST      8'h00
`define LCR_FUNC_RST      8'h00
`define LCR_DUTY_RST      8'h00
`define LCR_DRV_RST       8'hAF
`define LCR_LOG_BIT       7
`define LCR_CHIP_BIT      6
`define LCR_RED           2
`define LCR_GREEN         1
`define LCR_BLUE          0
// ----------------------------------------------------------------
// timing (host side spacing between writes)
// ----------------------------------------------------------------
`define LCR_MCLK_MHZ      20
`define LCR_CTRL_GAP_US   488
`define LCR_FUNC_GAP_US   153
`define LCR_CTRL_GAP_CYC  (`LCR_CTRL_GAP_US * `LCR_MCLK_MHZ)
`define LCR_FUNC_GAP_CYC  (`LCR_FUNC_GAP_US * `LCR_MCLK_MHZ)
`endif

// >>> inc/lcr_pkg.sv
// types shared by the led channel control block
package lcr_pkg;
  typedef enum logic [1:0] {
    EX_HOLD = 2'h0,
    EX_STEP = 2'h1,
    EX_RUN  = 2'h2,
    EX_ONCE = 2'h3
  } lcr_exec_type;
  typedef enum logic [1:0] {
    FN_OFF    = 2'h0,
    FN_LOAD   = 2'h1,
    FN_PROG   = 2'h2,
    FN_DIRECT = 2'h3
  } lcr_func_type;
  typedef enum logic [4:0] {
    IS_IDLE = 5'h01,
    IS_DEV  = 5'h02,
    IS_REG  = 5'h04,
    IS_WDAT = 5'h08,
    IS_RDAT = 5'h10
  } lcr_i2c_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } lcr_wr_type;
endpackage : lcr_pkg

// >>> tb/lcr_host.sv
// i2c host model for the led channel control registers
`include "lcr_regs.svh"
module lcr_host #(
  parameter logic [6:0] DEV = 7'h2A
) (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // program counters are never accessed, so the hold-only access is kept
  int cyc       = 0;
  int last_ctrl = -100000;
  int last_func = -100000;
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  always @(posedge mclk_i) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  task automatic q();
    repeat (10) @(posedge mclk_i);
  endtask : q
  task automatic start();
    pull_o <= 1'b0;
    q();
    scl_o <= 1'b1;
    q();
    pull_o <= 1'b1;
    q();
    scl_o <= 1'b0;
    q();
  endtask : start
  task automatic stop();
    pull_o <= 1'b1;
    q();
    scl_o <= 1'b1;
    q();
    pull_o <= 1'b0;
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    pull_o <= ~b;
    q();
    scl_o <= 1'b1;
    q();
    s = sda_i;
    q();
    scl_o <= 1'b0;
    q();
  endtask : bit_io
  task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ab, ack);
  endtask : byte_io
  // ----------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic       n0;
    logic       n1;
    logic       n2;
    while (a == `LCR_OFS_CTRL && cyc - last_ctrl <= `LCR_CTRL_GAP_CYC) begin
      @(posedge mclk_i);
    end
    while (a == `LCR_OFS_FUNC && cyc - last_func <= `LCR_FUNC_GAP_CYC) begin
      @(posedge mclk_i);
    end
    start();
    byte_io({DEV, 1'b0}, 1'b1, r, n0);
    byte_io(a, 1'b1, r, n1);
    byte_io(d, 1'b1, r, n2);
    stop();
    nak = n0 | n1 | n2;
    if (a == `LCR_OFS_CTRL) last_ctrl = cyc;
    if (a == `LCR_OFS_FUNC) last_func = cyc;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic       n;
    start();
    byte_io({DEV, 1'b0}, 1'b1, r, n);
    byte_io(a, 1'b1, r, n);
    start();
    byte_io({DEV, 1'b1}, 1'b1, r, n);
    byte_io(8'hFF, 1'b1, d, n);
    stop();
  endtask : read_reg
  task automatic probe(input logic [6:0] dv, output logic nak);
    logic [7:0] r;
    start();
    byte_io({dv, 1'b0}, 1'b1, r, nak);
    stop();
  endtask : probe
endmodule : lcr_host

// >>> tb/lcr_ctrl_tb.sv
// testbench for the led channel control registers
`include "lcr_regs.svh"
module lcr_ctrl_tb import lcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = 7'h2A;  // arbitrary bus address
  logic             mclk    = 1'b0;
  logic             resetn  = 1'b0;
  logic             clk_32k = 1'b0;
  logic             en_pin  = 1'b1;
  wire logic        scl;
  wire logic        pull;
  wire logic        sda;
  logic             sda_oe;
  logic             sda_do;
  logic             log_shape;
  logic             chip_en;
  logic             startup;
  logic [7:0]       red_drive;
  logic [2:0][7:0]  duty;
  logic [2:0]       instr;
  logic [2:0][3:0]  pc;
  int               n_mismatch = 0;
  int               n_checks   = 0;
  int               n_start    = 0;
  int               n_ins [3]  = '{0, 0, 0};
  assign sda = ~pull & (sda_oe ? sda_do : 1'b1);  // pull-up on the data line
  always #25 mclk = ~mclk;
  initial begin
    #37;
    forever #80 clk_32k = ~clk_32k;
  end
  always @(posedge mclk) if (startup === 1'b1) n_start++;
  always @(posedge clk_32k) begin
    for (int c = 0; c < 3; c++) if (instr[c] === 1'b1) n_ins[c]++;
  end
  lcr_host #(.DEV(DEV)) host (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  lcr_ctrl #(.DEV_ADDR(DEV)) dut (
    .mclk_i(mclk), .resetn_i(resetn), .clk_32k_i(clk_32k), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_do), .sda_oe_o(sda_oe), .en_pin_i(en_pin), .log_shape_o(log_shape),
    .chip_en_o(chip_en), .startup_o(startup), .red_drive_o(red_drive), .duty_o(duty),
    .instr_o(instr), .pc_o(pc));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    logic       n;
    check("drive out", red_drive, 8'hAF);
    check("duty out", duty, 24'h0);
    for (int a = 0; a < 7; a++) begin
      host.read_reg(8'(a), d);
      check("reset reg", d, (a == 5) ? 8'hAF : 8'h00);
    end
    host.probe(7'h30, n);
    check("foreign addr nak", n, 1'b1);
  endtask : t_reset
  task automatic t_direct();
    logic [7:0] d;
    logic [7:0] v;
    logic       n;
    host.write_reg(`LCR_OFS_FUNC, {2'b00, FN_DIRECT, FN_DIRECT, FN_DIRECT}, n);
    for (int c = 0; c < 3; c++) begin
      v = 8'h80 + 8'(c) * 8'h3F;
      host.write_reg(8'(4 - c), v, n);
      check("duty now", duty[c], v);
      host.read_reg(8'(4 - c), d);
      check("duty reg", d, v);
    end
    host.write_reg(`LCR_OFS_FUNC, {2'b00, FN_DIRECT, FN_OFF, FN_DIRECT}, n);
    check("green off", duty[1], 8'h00);
    check("red kept", duty[2], 8'hFE);
  endtask : t_direct
  task automatic t_enable();
    logic [7:0] d;
    logic       n;
    int         s0;
    s0 = n_start;
    host.write_reg(`LCR_OFS_CTRL, 8'hC0, n);
    repeat (4) @(posedge mclk);
    check("chip en", chip_en, 1'b1);
    check("startup pulses", 24'(n_start - s0), 24'd1);
    check("log shape", log_shape, 1'b1);
    check("log duty", duty[2], 8'hFC);
    en_pin <= 1'b0;
    repeat (8) @(posedge mclk);
    check("chip en forced", chip_en, 1'b0);
    host.read_reg(`LCR_OFS_CTRL, d);
    check("ctrl after pin", d, 8'h80);
    en_pin <= 1'b1;
  endtask : t_enable
  task automatic t_engine();
    logic [7:0] d;
    logic       n;
    int         s;
    logic [3:0] p0;
    logic [3:0] p1;
    host.write_reg(`LCR_OFS_FUNC, {2'b00, FN_PROG, FN_OFF, FN_DIRECT}, n);
    s = n_ins[2];
    host.write_reg(`LCR_OFS_CTRL, {2'b01, EX_STEP, EX_RUN, EX_HOLD}, n);
    repeat (40) @(posedge mclk);
    check("step pc", pc[2], 4'h1);
    check("step count", 24'(n_ins[2] - s), 24'd1);
    host.read_reg(`LCR_OFS_CTRL, d);
    check("step back hold", d, {2'b01, EX_HOLD, EX_RUN, EX_HOLD});
    check("green idle pc", pc[1], 4'h0);
    check("green idle count", 24'(n_ins[1]), 24'd0);
    host.write_reg(`LCR_OFS_CTRL, {2'b01, EX_ONCE, EX_HOLD, EX_HOLD}, n);
    repeat (40) @(posedge mclk);
    check("once pc", pc[2], 4'h1);
    check("once count", 24'(n_ins[2] - s), 24'd2);
    host.read_reg(`LCR_OFS_CTRL, d);
    check("once back hold", d, 8'h40);
    p0 = pc[2];
    s  = n_ins[2];
    host.write_reg(`LCR_OFS_CTRL, {2'b01, EX_RUN, EX_HOLD, EX_HOLD}, n);
    repeat (40) @(posedge mclk);
    check("running", 24'((n_ins[2] - s) > 3), 24'd1);
    host.write_reg(`LCR_OFS_CTRL, {2'b01, EX_HOLD, EX_HOLD, EX_HOLD}, n);
    repeat (10) @(posedge mclk);
    p1 = pc[2];
    s  = n_ins[2] - s;
    check("run pc track", p1, 4'(p0 + s));
    s = n_ins[2];
    repeat (40) @(posedge mclk);
    check("hold pc", pc[2], p1);
    check("hold count", 24'(n_ins[2] - s), 24'd0);
    host.write_reg(`LCR_OFS_FUNC, {2'b00, FN_LOAD, FN_OFF, FN_DIRECT}, n);
    repeat (40) @(posedge mclk);
    check("load pc", pc[2], 4'h0);
  endtask : t_engine
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (10) @(posedge mclk);
    t_reset();
    t_direct();
    t_enable();
    t_engine();
    stop_test();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule : lcr_ctrl_tb
